// File: design/status_event_reporting.sv
/*
 * status_event_reporting: event latch register, event mask, service request
 * mask and summary byte, reached through decoded commands from the parser.
 * assumes: command parser and output buffer logic run on ref_clk and give
 * one-cycle command and event pulses; power-on reset arrives on nrst.
 */
//
// Contract
// RULE1: event bits stick until read or cleared
// RULE2: event mask one enables bit for summary
// RULE3: enabled event rising sets summary bit five
// RULE4: event read or clear drops summary bit
// RULE5: bit zero set on operation complete
// RULE6: event bits one and six read zero
// RULE7: query error on three buffer conditions
// RULE8: device error on calibration or overflow
// RULE9: execution error when command cannot execute
// RULE10: command error when command not understood
// RULE11: bit seven set after power cycle
// RULE12: summary byte eight bits, low four zero
// RULE13: master bit from masked summary bits
// RULE14: message available set on response, cleared on terminator
// RULE15: summary byte bit seven reads zero
// RULE16: summary query changes no bit
// RULE17: clear status spares message available unless first
// RULE18: service mask write ignores bit six
// RULE19: masks written whole, others read only
// RULE20: event read returns value then clears
`timescale 1ns/1ps
`default_nettype none
module status_event_reporting (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire status_event_pkg::cmd_req_t cmd,
    input wire status_event_pkg::event_in_t events,
    input wire logic response_placed,
    input wire logic terminator_sent,
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output logic [7:0] summary_byte,
    output logic [7:0] event_latch_register,
    output logic [7:0] event_mask_register,
    output logic [7:0] service_request_mask
);

    logic is_read_summary;
    logic is_read_event;
    logic is_read_event_mask;
    logic is_read_srq_mask;
    logic is_write_event_mask;
    logic is_write_srq_mask;
    logic is_clear;
    logic event_clear;
    logic mav_clear;
    logic [7:0] ev_set;
    logic [7:0] ev_state;
    logic [7:0] ev_rose;
    logic any_enabled_rose;
    logic event_summary_bit;
    logic next_event_summary_bit;
    logic message_available_bit;
    logic next_message_available_bit;
    logic master_summary_bit;
    logic [7:0] summary_pre;
    logic [7:0] next_rsp_data;
    logic next_rsp_valid;
    logic power_seen;

    // command decode; only masks have write codes, others are read only
    assign is_read_summary = cmd.valid & (cmd.code == status_event_pkg::cmd_read_summary);
    assign is_read_event = cmd.valid & (cmd.code == status_event_pkg::cmd_read_event);
    assign is_read_event_mask = cmd.valid & (cmd.code == status_event_pkg::cmd_read_event_mask);
    assign is_read_srq_mask = cmd.valid & (cmd.code == status_event_pkg::cmd_read_srq_mask);
    assign is_write_event_mask = cmd.valid & (cmd.code == status_event_pkg::cmd_write_event_mask); // RULE19
    assign is_write_srq_mask = cmd.valid & (cmd.code == status_event_pkg::cmd_write_srq_mask); // RULE19
    assign is_clear = cmd.valid & (cmd.code == status_event_pkg::cmd_clear_status);

    // the event register clears on its query or on clear status
    assign event_clear = is_read_event | is_clear; // RULE1 RULE20
    assign mav_clear = terminator_sent | (is_clear & cmd.first_in_line); // RULE14 RULE17

    // event sources onto bit positions; bits one and six never set
    always_comb
    begin
        ev_set = status_event_pkg::zero_byte;
        ev_set[status_event_pkg::ev_opc_bit] = events.op_complete; // RULE5
        ev_set[status_event_pkg::ev_qye_bit] = events.read_empty | events.line_unread | events.buffers_full; // RULE7
        ev_set[status_event_pkg::ev_dde_bit] = events.cal_bad_input | events.rx_overflow; // RULE8
        ev_set[status_event_pkg::ev_exe_bit] = events.exec_fail; // RULE9
        ev_set[status_event_pkg::ev_cme_bit] = events.parse_fail; // RULE10
        ev_set[status_event_pkg::ev_pon_bit] = ~power_seen; // RULE11
    end

    // power-on flag: the first cycle after reset is the power-up event
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            power_seen <= 1'b0;
        else
            power_seen <= 1'b1;
    end

    // one sticky latch per used event bit
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_ev
            if (status_event_pkg::ev_used_mask[gi])
            begin : g_used
                event_bit_latch #(
                    .reset_value(status_event_pkg::event_reset[gi])
                ) u_latch (
                    .ref_clk(ref_clk),
                    .nrst(nrst),
                    .set(ev_set[gi]),
                    .clear(event_clear),
                    .state(ev_state[gi]),
                    .rose(ev_rose[gi])
                ); // RULE1
            end
            else
            begin : g_unused
                assign ev_state[gi] = 1'b0; // RULE6
                assign ev_rose[gi] = 1'b0;
            end
        end
    endgenerate

    // summary bit follows enabled rising events, set wins over clear
    assign any_enabled_rose = |(ev_rose & event_mask_register); // RULE2 RULE3
    assign next_event_summary_bit = any_enabled_rose | (event_summary_bit & ~event_clear); // RULE4

    // message available: set on response placed, set wins over clear
    assign next_message_available_bit = response_placed | (message_available_bit & ~mav_clear); // RULE14

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            event_summary_bit <= 1'b0;
            message_available_bit <= 1'b0;
        end
        else
        begin
            event_summary_bit <= next_event_summary_bit;
            message_available_bit <= next_message_available_bit;
        end
    end

    // mask registers written whole; bit six of the service mask dropped
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            event_mask_register <= status_event_pkg::mask_reset;
            service_request_mask <= status_event_pkg::mask_reset;
        end
        else
        begin
            if (is_write_event_mask)
                event_mask_register <= cmd.data; // RULE19
            if (is_write_srq_mask)
                service_request_mask <= cmd.data & status_event_pkg::srq_write_mask; // RULE18
        end
    end

    // summary byte: low nibble and bit seven stay zero
    always_comb
    begin
        summary_pre = status_event_pkg::zero_byte; // RULE12 RULE15
        summary_pre[status_event_pkg::sb_mav_bit] = message_available_bit;
        summary_pre[status_event_pkg::sb_esb_bit] = event_summary_bit;
    end

    assign master_summary_bit =
        |(summary_pre & service_request_mask & status_event_pkg::sb_summary_mask); // RULE13

    always_comb
    begin
        summary_byte = summary_pre;
        summary_byte[status_event_pkg::sb_mss_bit] = master_summary_bit;
    end

    assign event_latch_register = ev_state;

    // query answer mux; a summary read only samples, never clears
    assign next_rsp_valid = is_read_summary | is_read_event | is_read_event_mask | is_read_srq_mask;
    assign next_rsp_data = is_read_summary ? summary_byte : // RULE16
                           is_read_event ? ev_state : // RULE20
                           is_read_event_mask ? event_mask_register :
                           is_read_srq_mask ? service_request_mask :
                           status_event_pkg::zero_byte;

    // answer registered one cycle after the query, with pre-clear value
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rsp_valid <= 1'b0;
            rsp_data <= status_event_pkg::zero_byte;
        end
        else
        begin
            rsp_valid <= next_rsp_valid;
            rsp_data <= next_rsp_data;
        end
    end

endmodule
`default_nettype wire

// File: inc/status_event_pkg.sv
/*
 * status_event_pkg: bit positions, reset values, command codes and carrier
 * structs for the status and event reporting block.
 * assumes: included before any design file that names status_event_pkg.
 */
package status_event_pkg;

    localparam int ev_opc_bit = 0;
    localparam int ev_qye_bit = 2;
    localparam int ev_dde_bit = 3;
    localparam int ev_exe_bit = 4;
    localparam int ev_cme_bit = 5;
    localparam int ev_pon_bit = 7;
    localparam logic [7:0] ev_used_mask = 8'h_00BD;
    localparam int sb_mav_bit = 4;
    localparam int sb_esb_bit = 5;
    localparam int sb_mss_bit = 6;
    localparam logic [7:0] sb_summary_mask = 8'h_00BE;
    localparam logic [7:0] srq_write_mask = 8'h_00BF;
    localparam logic [7:0] mask_reset = 8'h_0000;
    localparam logic [7:0] event_reset = 8'h_0080;
    localparam logic [7:0] zero_byte = 8'h_0000;

    typedef enum logic [2:0] {
        cmd_none,
        cmd_read_summary,
        cmd_read_event,
        cmd_read_event_mask,
        cmd_read_srq_mask,
        cmd_write_event_mask,
        cmd_write_srq_mask,
        cmd_clear_status
    } cmd_code_t;

    typedef struct packed {
        logic valid;
        cmd_code_t code;
        logic first_in_line;
        logic [7:0] data;
    } cmd_req_t;

    typedef struct packed {
        logic op_complete;
        logic read_empty;
        logic line_unread;
        logic buffers_full;
        logic cal_bad_input;
        logic rx_overflow;
        logic exec_fail;
        logic parse_fail;
    } event_in_t;

endpackage

// File: design/event_bit_latch.sv
/*
 * event_bit_latch: one sticky event bit with a rising-edge indication.
 * assumes: set and clear come from logic on ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module event_bit_latch #(
    parameter logic reset_value = 1'b0
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic set,
    input wire logic clear,
    output logic state,
    output logic rose
);

    logic next_state;

    // set beats clear so an event in the clearing cycle survives
    assign next_state = set | (state & ~clear);
    assign rose = next_state & ~state;

    // sticky storage
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            state <= reset_value;
        else
            state <= next_state;
    end

endmodule
`default_nettype wire

// File: testbench/status_event_reporting_chk.sv
/*
 * status_event_reporting_chk: concurrent checks on the block's ports.
 * assumes: bound into status_event_reporting, one clock, async low reset.
 */
`timescale 1ns/1ps
`default_nettype none
module status_event_reporting_chk (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire status_event_pkg::cmd_req_t cmd,
    input wire status_event_pkg::event_in_t events,
    input wire logic response_placed,
    input wire logic terminator_sent,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_data,
    input wire logic [7:0] summary_byte,
    input wire logic [7:0] event_latch_register,
    input wire logic [7:0] event_mask_register,
    input wire logic [7:0] service_request_mask
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // decoded read and clear strobes of the event register
    wire logic ev_rd = cmd.valid && cmd.code == status_event_pkg::cmd_read_event;
    wire logic ev_clr = cmd.valid && cmd.code == status_event_pkg::cmd_clear_status;
    wire logic ev_none = events == 8'h00;
    a_summary_fixed_zero: assert property ((summary_byte & 8'h8F) == 8'h00)
        else $error("summary byte unused bits set");
    a_event_unused_zero: assert property ((event_latch_register & 8'h42) == 8'h00)
        else $error("event unused bits set");
    a_srq_six_zero: assert property (!service_request_mask[6])
        else $error("service mask bit six set");
    a_master_bit_calc: assert property (summary_byte[6] == |(summary_byte & service_request_mask & 8'hBE))
        else $error("master bit wrong");
    a_event_bits_stick: assert property (!ev_rd && !ev_clr |=>
        (event_latch_register & $past(event_latch_register)) == $past(event_latch_register))
        else $error("event bit lost");
    a_event_read_clears: assert property (ev_rd && ev_none |=>
        rsp_valid && rsp_data == $past(event_latch_register) && event_latch_register == 8'h00)
        else $error("event read wrong");
    a_summary_drop: assert property ((ev_rd || ev_clr) && ev_none |=> !summary_byte[5])
        else $error("event summary not dropped");
    a_opc_sets_bit: assert property (events.op_complete |=> event_latch_register[0])
        else $error("operation complete not latched");
    a_msg_avail_set: assert property (response_placed |=> summary_byte[4])
        else $error("message available not set");
    a_mask_write_whole: assert property (cmd.valid && cmd.code == status_event_pkg::cmd_write_event_mask
        |=> event_mask_register == $past(cmd.data))
        else $error("event mask not written");
endmodule
bind status_event_reporting status_event_reporting_chk chk_u (.ref_clk, .nrst, .cmd, .events, .response_placed,
    .terminator_sent, .rsp_valid, .rsp_data, .summary_byte, .event_latch_register, .event_mask_register,
    .service_request_mask);
`default_nettype wire

// File: testbench/host_model.sv
/*
 * host_model: the host computer side, issuing decoded commands one byte each.
 * assumes: driven at the falling edge of ref_clk, answers one cycle later.
 */
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic ref_clk,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_data,
    output status_event_pkg::cmd_req_t cmd
);
    initial cmd = '0;
    // one command per call; a missing answer comes back unknown so it never matches
    task automatic xfer(input status_event_pkg::cmd_code_t code, input logic [7:0] d, input logic f,
        output logic [7:0] r);
        @(negedge ref_clk);
        cmd = '{1'b1, code, f, d};
        @(negedge ref_clk);
        cmd.valid = 1'b0;
        r = rsp_valid ? rsp_data : 8'hxx;
    endtask
endmodule
`default_nettype wire

// File: testbench/tb_status_event_reporting.sv
/*
 * tb_status_event_reporting: command sequences with expected register values.
 * assumes: host_model and the bound checker are compiled alongside.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_status_event_reporting;
    logic ref_clk = 0, nrst = 0, rv;
    logic [9:0] drv = '0;
    logic [7:0] r, sb, ev, em, sm, rd;
    status_event_pkg::cmd_req_t cmd;
    int error_cnt = 0, total_checks = 0;
    int pos[8] = '{0, 2, 2, 2, 3, 3, 4, 5};
    always #12.5 ref_clk = ~ref_clk;
    status_event_reporting dut_u (.ref_clk(ref_clk), .nrst(nrst), .cmd(cmd), .events(drv[9:2]),
        .response_placed(drv[1]), .terminator_sent(drv[0]), .rsp_valid(rv), .rsp_data(rd),
        .summary_byte(sb), .event_latch_register(ev), .event_mask_register(em), .service_request_mask(sm));
    host_model host_u (.ref_clk(ref_clk), .rsp_valid(rv), .rsp_data(rd), .cmd(cmd));
    task automatic end_sim;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // one-cycle pulse on events, placed and sent, result visible at the next fall
    task automatic pulse(input logic [9:0] p);
        @(negedge ref_clk);
        drv = p;
        @(negedge ref_clk);
        drv = '0;
    endtask
    initial
    begin
        repeat (12) @(negedge ref_clk);
        nrst = 1;
        `CHK("ev_reset", 8'h80, ev)
        host_u.xfer(status_event_pkg::cmd_read_event, 8'h00, 0, r);
        `CHK("ev_read", 8'h80, r)
        `CHK("ev_after", 8'h00, ev)
        for (int i = 0; i < 8; i++)
        begin
            pulse({8'h80 >> i, 2'b00});
            host_u.xfer(status_event_pkg::cmd_read_event, 8'h00, 0, r);
            `CHK("ev_bit", 8'h01 << pos[i], r)
        end
        host_u.xfer(status_event_pkg::cmd_write_event_mask, 8'h10, 0, r);
        host_u.xfer(status_event_pkg::cmd_read_event_mask, 8'h00, 0, r);
        `CHK("ev_mask", 8'h10, r)
        pulse(10'h004);
        `CHK("sb_masked", 8'h00, sb)
        pulse(10'h008);
        `CHK("sb_esb", 8'h20, sb)
        host_u.xfer(status_event_pkg::cmd_write_srq_mask, 8'hFF, 0, r);
        host_u.xfer(status_event_pkg::cmd_read_srq_mask, 8'h00, 0, r);
        `CHK("srq_mask", 8'hBF, r)
        for (int i = 0; i < 2; i++)
        begin
            host_u.xfer(status_event_pkg::cmd_read_summary, 8'h00, 0, r);
            `CHK("sb_query", 8'h60, r)
        end
        pulse(10'h002);
        `CHK("sb_mav", 8'h70, sb)
        host_u.xfer(status_event_pkg::cmd_clear_status, 8'h00, 0, r);
        `CHK("sb_cls_late", 8'h50, sb)
        host_u.xfer(status_event_pkg::cmd_clear_status, 8'h00, 1, r);
        `CHK("sb_cls_first", 8'h00, sb)
        pulse(10'h002);
        pulse(10'h001);
        `CHK("sb_term", 8'h00, sb)
        pulse(10'h008);
        host_u.xfer(status_event_pkg::cmd_read_event, 8'h00, 0, r);
        `CHK("ev_exe", 8'h10, r)
        `CHK("sb_esr_read", 8'h00, sb)
        end_sim();
    end
    // hang guard, well past the roughly 80 cycles the sequence needs
    initial
    begin
        #100us;
        error_cnt++;
        end_sim();
    end
endmodule
`default_nettype wire
